// ==== bench/spcc_link_props.sv ====
`default_nettype none
// link watcher: bit clock shape, byte framing and pacing between frames
module spcc_link_props (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic cmd_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  logic [3:0] rise_q; // bit clocks seen in the open frame
  logic [8:0] gap_q; // idle cycles since the last frame, saturating
  // bit clocks per frame; cleared whenever the frame is closed
  always_ff @(posedge clock) begin
    if (!nrst || cs_n) begin
      rise_q <= 4'h0;
    end else if ($rose(sclk)) begin
      rise_q <= rise_q + 4'h1;
    end
  end
  // starts saturated so the first frame after reset is never judged too close
  always_ff @(posedge clock) begin
    if (!nrst) begin
      gap_q <= 9'h1ff;
    end else if (!cs_n) begin
      gap_q <= 9'h000;
    end else if (gap_q != 9'h1ff) begin
      gap_q <= gap_q + 9'h001;
    end
  end
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("bit clock high outside a frame");
  chk_byte_len: assert property ($rose(cs_n) |-> rise_q == 4'h8)
    else $error("frame did not carry eight bit clocks");
  chk_half_high: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("bit clock high phase not eight cycles");
  chk_half_low: assert property ($fell(sclk) && !cs_n |-> !sclk [*8])
    else $error("bit clock low phase shorter than eight cycles");
  chk_clk_framed: assert property ($rose(sclk) |-> !$past(cs_n))
    else $error("bit clock rose without an open frame");
  chk_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("command data moved while bit clock high");
  chk_sdo_hold: assert property (sclk && $past(sclk) |-> $stable(sdo))
    else $error("status data moved while bit clock high");
  chk_cmd_gap: assert property ($fell(cs_n) |-> gap_q >= 9'(spcc_pkg::CMD_GAP_CYC))
    else $error("frames closer than the command gap");
  // busy pin activity seen at least once
  cover property ($fell(cmd_busy_n));
endmodule : spcc_link_props
`default_nettype wire

// ==== bench/speech_playback_command_core_tb_top.sv ====
`default_nettype none
// bench top: host end drives the link, device end answers, a model predicts results
module speech_playback_command_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin num_errors++; \
    $display("ERROR %s exp %0h got %0h", nm, ex, gt); end end
  localparam int unsigned FADE = 20; // shortened fade so stop timing is measurable
  // clock, reset and register port
  logic clock, nrst, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, lfsr_q;
  // phrase engine stimulus and device outputs
  logic addr_done, play_end, play_start, play_halt, fade_active, cmd_ready, play_busy_n;
  logic pwr_on, dac_pwr, spk_pwr, line_on_spk_pos, dac_path_on, dac_gain_full, ain_path_on;
  logic ain_gain_full, line_ramp_busy, line_level_up;
  logic [9:0] play_phrase, m_exp;
  // model: expected levels, settings byte, phrases due to start
  logic m_rdy, m_bsy;
  logic [7:0] m_set;
  logic [9:0] q_phr[$];
  int num_errors, num_checks, n_halt;
  spcc_link_if link ();
  spcc_host #(.STOP_WAIT(50)) spcc_host_i (.clock(clock), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
  spcc_dev #(.FADE_CYC(FADE)) spcc_dev_i (.clock(clock), .nrst(nrst), .link(link),
    .play_start(play_start), .play_phrase(play_phrase), .play_halt(play_halt),
    .fade_active(fade_active), .addr_done(addr_done), .play_end(play_end),
    .cmd_ready(cmd_ready), .play_busy_n(play_busy_n), .pwr_on(pwr_on), .dac_pwr(dac_pwr),
    .spk_pwr(spk_pwr), .line_on_spk_pos(line_on_spk_pos), .dac_path_on(dac_path_on),
    .dac_gain_full(dac_gain_full), .ain_path_on(ain_path_on), .ain_gain_full(ain_gain_full),
    .line_ramp_busy(line_ramp_busy), .line_level_up(line_level_up));
  spcc_link_props spcc_link_props_i (.clock(clock), .nrst(nrst), .sclk(link.sclk),
    .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo), .cmd_busy_n(link.cmd_busy_n));
  // 10 mhz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard, about four times the expected run
  initial begin
    repeat (80000) @(posedge clock);
    num_errors++;
    close_out();
  end
  // one-cycle pulses sampled mid-cycle so none slips by
  always @(negedge clock) begin
    if (play_halt === 1'b1) n_halt++;
    if (play_start === 1'b1) begin
      if (q_phr.size() == 0) begin
        num_errors++;
        $display("ERROR start exp none got %0h", play_phrase);
      end else begin
        m_exp = q_phr.pop_front();
        `CHK("phrase", m_exp, play_phrase)
      end
    end
  end
  // counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  // register port cycles: one-cycle strobes, read data in the next cycle
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // poll the host until it has sent everything, gaps included
  task automatic idle();
    logic [31:0] d;
    int n;
    n = 0;
    d = 32'h0;
    while (d[0] !== 1'b1 && n < 3000) begin
      rreg(spcc_pkg::HR_STAT, d);
      n++;
    end
    `CHK("host idle", 1'b1, d[0])
  endtask : idle
  task automatic cmd(input logic [7:0] b1, input logic [7:0] b2, input logic two,
                     input logic st);
    wreg(spcc_pkg::HR_CMD, {14'h0, st, two, b2, b1});
    idle();
    repeat (10) @(posedge clock);
  endtask : cmd
  task automatic play(input logic [9:0] p);
    q_phr.push_back(p);
    cmd({spcc_pkg::OP_PLAY_HI, p[9:8], 2'h0}, p[7:0], 1'b1, 1'b0);
  endtask : play
  // status byte only carries busy and ready
  task automatic stat();
    logic [31:0] d;
    cmd(spcc_pkg::OP_READ_STATUS_CMD, 8'h00, 1'b0, 1'b1);
    rreg(spcc_pkg::HR_STAT, d);
    `CHK("status", {m_bsy, m_rdy}, {d[13], d[8]})
  endtask : stat
  // phrase engine pulse: address control done or phrase end
  task automatic eng(input logic ad);
    @(posedge clock);
    addr_done <= ad;
    play_end <= ~ad;
    @(posedge clock);
    addr_done <= 1'b0;
    play_end <= 1'b0;
    repeat (10) @(posedge clock);
  endtask : eng
  task automatic wait_lvl(input logic up);
    int n;
    n = 0;
    while ((up ? cmd_ready : ~pwr_on) !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    `CHK("power state", 1'b1, up ? cmd_ready : ~pwr_on)
    repeat (4) @(posedge clock);
  endtask : wait_lvl
  // ready, busy and analog setting outputs against the model
  task automatic chk_all(input string nm);
    `CHK("ready", m_rdy, cmd_ready)
    `CHK("busy", m_bsy, play_busy_n)
    `CHK("dac power", m_set[2], dac_pwr)
    `CHK("level up", m_set[2], line_level_up)
    `CHK("spk power", m_set[1], spk_pwr)
    `CHK("line pin", ~m_set[1], line_on_spk_pos)
    `CHK("dac path", (m_set[6:5] != 2'h0) & m_set[1], dac_path_on)
    `CHK("dac full", m_set[6:5] != 2'h1, dac_gain_full)
    `CHK("ain path", (m_set[4:3] != 2'h0) & m_set[1], ain_path_on)
    `CHK("ain full", m_set[4:3] != 2'h1, ain_gain_full)
    $display("test %s done, errors %0d", nm, num_errors);
  endtask : chk_all
  initial begin : main
    logic [7:0] v;
    int n, k, lim;
    logic seen;
    {nrst, wr, rd, addr_done, play_end, addr, wdata} = '0;
    {num_errors, num_checks, n_halt} = '0;
    lfsr_q = 32'h36f4;
    {m_rdy, m_bsy, m_set} = {2'b01, spcc_pkg::AS_INIT};
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (8) @(posedge clock);
    chk_all("reset");
    // setup while off is dropped whole
    cmd(spcc_pkg::OP_ASET, 8'hff, 1'b1, 1'b0);
    `CHK("still off", 1'b0, pwr_on)
    chk_all("setup while off");
    lfsr_q = lfsr_next(lfsr_q);
    cmd({6'h00, lfsr_q[1:0]}, 8'h00, 1'b0, 1'b0);
    wait_lvl(1'b1);
    m_rdy = 1'b1;
    chk_all("power up");
    stat();
    // all gain codes, dac toggling, random pop choosing ramp length
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      v = {1'b0, i[1:0], ~i[1:0], i[0], i[1], lfsr_q[0]};
      cmd(spcc_pkg::OP_ASET, v, 1'b1, 1'b0);
      `CHK("ramp run", v[2] ^ m_set[2], line_ramp_busy)
      m_set = v;
      chk_all("analog setup");
      if (v[2]) lim = v[0] ? spcc_pkg::RUP_L_CYC : spcc_pkg::RUP_S_CYC;
      else lim = v[0] ? spcc_pkg::RDN_L_CYC : spcc_pkg::RDN_S_CYC;
      n = 0;
      while (line_ramp_busy !== 1'b0 && n < 4000) begin
        @(negedge clock);
        n++;
      end
      if (i > 0) `CHK("ramp time", 1'b1, (n <= lim) && (n + 700 > lim))
    end
    lfsr_q = lfsr_next(lfsr_q);
    play(lfsr_q[9:0]);
    {m_rdy, m_bsy} = 2'b00;
    chk_all("play");
    eng(1'b1);
    m_rdy = 1'b1;
    chk_all("address done");
    stat();
    cmd(spcc_pkg::OP_ASET, 8'h00, 1'b1, 1'b0);
    chk_all("setup while playing");
    // second phrase queued, starts at the end of the first
    lfsr_q = lfsr_next(lfsr_q);
    play(lfsr_q[9:0]);
    m_rdy = 1'b0;
    chk_all("chain queued");
    eng(1'b0);
    `CHK("chain start", 0, q_phr.size())
    chk_all("chain started");
    eng(1'b1);
    eng(1'b0);
    {m_rdy, m_bsy} = 2'b11;
    chk_all("chain end");
    // stop with fade off after address control, then fade on during it
    for (int f = 0; f < 2; f++) begin
      m_set[7] = f[0];
      cmd(spcc_pkg::OP_ASET, m_set, 1'b1, 1'b0);
      lfsr_q = lfsr_next(lfsr_q);
      play(lfsr_q[9:0]);
      if (f == 0) eng(1'b1);
      k = n_halt;
      wreg(spcc_pkg::HR_CMD, {24'h0, spcc_pkg::OP_STOP});
      n = 0;
      while (play_halt !== 1'b1 && n < 2000) begin
        @(negedge clock);
        n++;
      end
      seen = 1'b0;
      n = 0;
      while (play_busy_n !== 1'b1 && n < 100) begin
        @(negedge clock);
        seen = seen | (fade_active === 1'b1);
        n++;
      end
      `CHK("fade length", 1'b1, (n >= FADE * f) && (n <= FADE * f + 4))
      `CHK("fade flag", f[0], seen)
      idle();
      `CHK("halts", k + 1, n_halt)
      chk_all("stop");
    end
    // preset then launch; power-down keeps settings and clears the preset, power-up reloads AS_INIT
    lfsr_q = lfsr_next(lfsr_q);
    m_exp = lfsr_q[9:0];
    cmd({spcc_pkg::OP_SET_HI, m_exp[9:8], 2'h0}, m_exp[7:0], 1'b1, 1'b0);
    chk_all("preset");
    q_phr.push_back(m_exp);
    cmd(spcc_pkg::OP_LAUNCH, 8'h00, 1'b0, 1'b0);
    `CHK("launch", 0, q_phr.size())
    eng(1'b1);
    eng(1'b0);
    cmd(spcc_pkg::OP_POWER_DOWN_CMD, 8'h00, 1'b0, 1'b0);
    wait_lvl(1'b0);
    m_rdy = 1'b0;
    chk_all("power down");
    cmd(8'h00, 8'h00, 1'b0, 1'b0);
    wait_lvl(1'b1);
    {m_rdy, m_set} = {1'b1, spcc_pkg::AS_INIT};
    chk_all("power up again");
    cmd(spcc_pkg::OP_LAUNCH, 8'h00, 1'b0, 1'b0);
    chk_all("launch after clear");
    close_out();
  end
endmodule : speech_playback_command_core_tb_top
`default_nettype wire

// ==== src/spcc_dev.sv ====
`default_nettype none
// device end: byte receiver, command decoder, playback and analog control
module spcc_dev #(
  parameter int unsigned FADE_CYC = spcc_pkg::FADE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // serial command link
  spcc_link_if.dev link,
  // phrase engine
  output logic play_start,
  output logic [9:0] play_phrase,
  output logic play_halt,
  output logic fade_active,
  input wire logic addr_done,
  input wire logic play_end,
  // status levels
  output logic cmd_ready,
  output logic play_busy_n,
  output logic pwr_on,
  // analog control
  output logic dac_pwr,
  output logic spk_pwr,
  output logic line_on_spk_pos,
  output logic dac_path_on,
  output logic dac_gain_full,
  output logic ain_path_on,
  output logic ain_gain_full,
  output logic line_ramp_busy,
  output logic line_level_up
);
  typedef enum logic [2:0] {
    D_OFF, D_TRANS, D_IDLE, D_WAIT2, D_ADDR, D_QUEUE, D_STOP
  } spcc_dst_e;

  spcc_dst_e st_q, st_d; // command state
  logic [16:0] cnt_q, cnt_d; // transition and fade timer
  logic [15:0] rmp_q, rmp_d; // line ramp timer
  logic [7:0] op_q, op_d; // first byte of two-byte command
  logic [7:0] as_q, as_d; // analog settings
  logic [9:0] pre_q, pre_d; // preset phrase
  logic pre_v_q, pre_v_d; // preset phrase stored
  logic [9:0] pend_q, pend_d; // chained phrase
  logic [9:0] ph_q, ph_d; // phrase being played
  logic play_q, play_d; // playback running
  logic pd_q, pd_d; // transition leads to power-down
  logic [7:0] rx_q; // receive shift
  logic [2:0] rxc_q; // received bit count
  logic [7:0] tx_q; // status shift
  logic rdf_q; // next frame carries status out
  logic start_d, halt_d, start_q, halt_q;

  // pin synchronisers
  logic sclk_l, sclk_r, sclk_f, cs_l, sdi_l;
  spcc_sync3 #(.INIT(1'b0)) u_sclk (
    .clock(clock), .nrst(nrst), .din(link.sclk),
    .lvl(sclk_l), .rise(sclk_r), .fall(sclk_f)
  );
  spcc_sync3 #(.INIT(1'b1)) u_cs (
    .clock(clock), .nrst(nrst), .din(link.cs_n),
    .lvl(cs_l), .rise(), .fall()
  );
  spcc_sync3 #(.INIT(1'b0)) u_sdi (
    .clock(clock), .nrst(nrst), .din(link.sdi),
    .lvl(sdi_l), .rise(), .fall()
  );

  // byte framing; a status frame carries a dummy byte that is not decoded
  wire bit_in = sclk_r && !cs_l;
  wire byte_v = bit_in && (rxc_q == 3'h7);
  wire [7:0] byte_w = {rx_q[6:0], sdi_l};
  wire cmd_v = byte_v && !rdf_q;

  // opcode decode
  wire is_rd = (byte_w == spcc_pkg::OP_READ_STATUS_CMD);
  wire is_aset = (byte_w == spcc_pkg::OP_ASET);
  wire is_stop = (byte_w == spcc_pkg::OP_STOP);
  wire is_launch = (byte_w == spcc_pkg::OP_LAUNCH);
  wire is_power_down_cmd = (byte_w == spcc_pkg::OP_POWER_DOWN_CMD);
  wire is_pup = (byte_w[7:2] == 6'h00);
  wire is_play = (byte_w[7:4] == spcc_pkg::OP_PLAY_HI) && (byte_w[1:0] == 2'h0);
  wire is_set = (byte_w[7:4] == spcc_pkg::OP_SET_HI) && (byte_w[1:0] == 2'h0);
  wire [9:0] addr_w = {op_q[3:2], byte_w};
  wire busy_w = play_q || (st_q == D_ADDR) || (st_q == D_QUEUE) || (st_q == D_STOP);
  wire [7:0] stat_w = 8'(32'(!busy_w) << spcc_pkg::ST_BUSY_BIT)
    | 8'(32'(st_q == D_IDLE) << spcc_pkg::ST_RDY_BIT);
  wire dac_new = as_d[spcc_pkg::AS_DAC_POWER_EN];
  wire pop_new = as_d[spcc_pkg::AS_POP];

  // serial receive and status transmit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rx_q <= 8'h00;
      rxc_q <= 3'h0;
      tx_q <= 8'h00;
      rdf_q <= 1'b0;
    end else begin
      if (cs_l) rxc_q <= 3'h0;
      else if (bit_in) rxc_q <= rxc_q + 3'h1;
      if (bit_in) rx_q <= byte_w;
      if (byte_v && rdf_q) rdf_q <= 1'b0;
      else if (cmd_v && is_rd) rdf_q <= 1'b1;
      // seven shifts a frame and none on the eighth fall, so a fresh status load stays whole
      if (cmd_v && is_rd) tx_q <= stat_w;
      else if (sclk_f && !cs_l && (rxc_q != 3'h0)) tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // command state machine
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    op_d = op_q;
    as_d = as_q;
    pre_d = pre_q;
    pre_v_d = pre_v_q;
    pend_d = pend_q;
    ph_d = ph_q;
    play_d = play_q;
    pd_d = pd_q;
    start_d = 1'b0;
    halt_d = 1'b0;
    // a phrase ends on its own unless one is chained behind it
    if (play_end && st_q != D_QUEUE) play_d = 1'b0;
    case (st_q)
      D_OFF: begin
        if (cmd_v && is_pup) begin
          st_d = D_TRANS;
          cnt_d = 17'(spcc_pkg::TRANS_CYC);
          pd_d = 1'b0;
          as_d = spcc_pkg::AS_INIT;
        end
      end
      // bytes dropped while power moves
      D_TRANS: begin
        if (cnt_q == 17'h0) st_d = pd_q ? D_OFF : D_IDLE;
        else cnt_d = cnt_q - 17'h1;
      end
      D_IDLE: begin
        if (cmd_v && (is_play || is_set)) begin
          st_d = D_WAIT2;
          op_d = byte_w;
        end else if (cmd_v && is_aset && !play_q) begin
          st_d = D_WAIT2;
          op_d = byte_w;
        end else if (cmd_v && is_launch && pre_v_q) begin
          ph_d = pre_q;
          start_d = 1'b1;
          play_d = 1'b1;
          st_d = D_ADDR;
        end else if (cmd_v && is_stop && play_q) begin
          halt_d = 1'b1;
          st_d = D_STOP;
          cnt_d = as_q[spcc_pkg::AS_FADE] ? 17'(FADE_CYC) : 17'h0;
        end else if (cmd_v && is_power_down_cmd && !play_q) begin
          st_d = D_TRANS;
          cnt_d = 17'(spcc_pkg::TRANS_CYC);
          pd_d = 1'b1;
          pre_v_d = 1'b0;
          pre_d = 10'h000;
        end
      end
      D_WAIT2: begin
        if (cmd_v) begin
          st_d = D_IDLE;
          if (op_q == spcc_pkg::OP_ASET) begin
            as_d = byte_w;
          end else if (op_q[7:4] == spcc_pkg::OP_SET_HI) begin
            pre_d = addr_w;
            pre_v_d = 1'b1;
          end else if (play_q) begin
            pend_d = addr_w;
            st_d = D_QUEUE;
          end else begin
            ph_d = addr_w;
            start_d = 1'b1;
            play_d = 1'b1;
            st_d = D_ADDR;
          end
        end
      end
      D_ADDR, D_QUEUE: begin
        if (cmd_v && is_stop) begin
          halt_d = 1'b1;
          st_d = D_STOP;
          cnt_d = as_q[spcc_pkg::AS_FADE] ? 17'(FADE_CYC) : 17'h0;
        end else if (st_q == D_ADDR && addr_done) begin
          st_d = D_IDLE;
        end else if (st_q == D_QUEUE && play_end) begin
          ph_d = pend_q;
          start_d = 1'b1;
          st_d = D_ADDR;
        end
      end
      D_STOP: begin
        if (cnt_q == 17'h0) begin
          st_d = D_IDLE;
          play_d = 1'b0;
        end else begin
          cnt_d = cnt_q - 17'h1;
        end
      end
      default: st_d = D_OFF;
    endcase
  end

  // line ramp timer restarts whenever the dac power bit flips
  always_comb begin
    rmp_d = (rmp_q == 16'h0) ? 16'h0 : rmp_q - 16'h1;
    if (dac_new != as_q[spcc_pkg::AS_DAC_POWER_EN]) begin
      if (dac_new) rmp_d = pop_new ? 16'(spcc_pkg::RUP_L_CYC) : 16'(spcc_pkg::RUP_S_CYC);
      else rmp_d = pop_new ? 16'(spcc_pkg::RDN_L_CYC) : 16'(spcc_pkg::RDN_S_CYC);
    end
  end

  // state registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_q <= D_OFF;
      cnt_q <= 17'h0;
      rmp_q <= 16'h0;
      op_q <= 8'h00;
      as_q <= spcc_pkg::AS_INIT;
      pre_q <= 10'h000;
      pre_v_q <= 1'b0;
      pend_q <= 10'h000;
      ph_q <= 10'h000;
      play_q <= 1'b0;
      pd_q <= 1'b0;
      start_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rmp_q <= rmp_d;
      op_q <= op_d;
      as_q <= as_d;
      pre_q <= pre_d;
      pre_v_q <= pre_v_d;
      pend_q <= pend_d;
      ph_q <= ph_d;
      play_q <= play_d;
      pd_q <= pd_d;
      start_q <= start_d;
      halt_q <= halt_d;
    end
  end

  // outputs; dac and ain paths open only with the speaker amplifier powered
  assign play_start = start_q;
  assign play_phrase = ph_q;
  assign play_halt = halt_q;
  assign fade_active = (st_q == D_STOP) && (cnt_q != 17'h0);
  assign cmd_ready = (st_q == D_IDLE);
  assign play_busy_n = !busy_w;
  assign pwr_on = (st_q != D_OFF) && !(st_q == D_TRANS && !pd_q);
  assign dac_pwr = as_q[spcc_pkg::AS_DAC_POWER_EN];
  assign spk_pwr = as_q[spcc_pkg::AS_SPK_POWER_EN];
  assign line_on_spk_pos = !as_q[spcc_pkg::AS_SPK_POWER_EN];
  assign dac_path_on = spk_pwr && (as_q[spcc_pkg::AS_DAG +: 2] != spcc_pkg::GAIN_OFF);
  assign dac_gain_full = as_q[spcc_pkg::AS_DAG +: 2] != spcc_pkg::GAIN_M6;
  assign ain_path_on = spk_pwr && (as_q[spcc_pkg::AS_AIG +: 2] != spcc_pkg::GAIN_OFF);
  assign ain_gain_full = as_q[spcc_pkg::AS_AIG +: 2] != spcc_pkg::GAIN_M6;
  assign line_ramp_busy = (rmp_q != 16'h0);
  assign line_level_up = dac_pwr;
  assign link.sdo = tx_q[7];
  assign link.cmd_busy_n = !((st_q == D_TRANS) || (st_q == D_ADDR) || (st_q == D_STOP));
endmodule : spcc_dev
`default_nettype wire

// ==== src/spcc_host.sv ====
`default_nettype none
// host end: register port in, serial command frames out
module spcc_host #(
  parameter int unsigned STOP_WAIT = spcc_pkg::STOP_WAIT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // serial command link
  spcc_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_FRAME, H_GAP, H_STOPW} spcc_hst_e;

  spcc_hst_e st_q; // sequencer state
  logic [7:0] b0_q, b1_q; // queued bytes
  logic two_q, rdst_q, sec_q; // second byte, status read, in second frame
  logic [7:0] sh_q; // shift out and in
  logic [3:0] ph_q; // half-bit phase
  logic [3:0] div_q; // half-bit divider
  logic [16:0] cnt_q; // gap and stop wait
  logic [7:0] stat_q; // last status byte
  logic stop_q; // last byte was a stop
  logic [31:0] rdata_q;
  logic sdo_l, cbn_l;

  // device pin synchronisers
  spcc_sync3 #(.INIT(1'b0)) u_sdo (
    .clock(clock), .nrst(nrst), .din(link.sdo),
    .lvl(sdo_l), .rise(), .fall()
  );
  spcc_sync3 #(.INIT(1'b1)) u_cbn (
    .clock(clock), .nrst(nrst), .din(link.cmd_busy_n),
    .lvl(cbn_l), .rise(), .fall()
  );

  wire idle = (st_q == H_IDLE);
  wire go = wr && (addr == spcc_pkg::HR_CMD) && idle;
  wire half_end = (div_q == 4'(spcc_pkg::HALF_CYC - 1));
  wire frame_end = half_end && (ph_q == 4'hf);
  wire more = two_q && !sec_q; // a second byte follows
  wire [31:0] stat_rd = {16'h0000, stat_q, 7'h00, idle};

  // read port, data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!nrst) rdata_q <= 32'h0;
    else if (rd) rdata_q <= (addr == spcc_pkg::HR_STAT) ? stat_rd : 32'h0;
  end
  assign rdata = rdata_q;

  // sequencer
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_q <= H_IDLE;
      {b0_q, b1_q, sh_q, stat_q} <= 32'h0;
      {two_q, rdst_q, sec_q, stop_q} <= 4'h0;
      ph_q <= 4'h0;
      div_q <= 4'h0;
      cnt_q <= 17'h0;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (go) begin
            b0_q <= wdata[7:0];
            b1_q <= wdata[spcc_pkg::HC_RD] ? 8'h00 : wdata[15:8];
            two_q <= wdata[spcc_pkg::HC_TWO] || wdata[spcc_pkg::HC_RD];
            rdst_q <= wdata[spcc_pkg::HC_RD];
            stop_q <= (wdata[7:0] == spcc_pkg::OP_STOP) && !wdata[spcc_pkg::HC_TWO];
            sec_q <= 1'b0;
            sh_q <= wdata[7:0];
            {ph_q, div_q} <= 8'h00;
            st_q <= H_FRAME;
          end
        end
        H_FRAME: begin
          div_q <= half_end ? 4'h0 : div_q + 4'h1;
          if (half_end) ph_q <= ph_q + 4'h1;
          // sample just before the falling edge, device data long settled
          if (half_end && ph_q[0]) sh_q <= {sh_q[6:0], sdo_l};
          if (frame_end) begin
            if (rdst_q && sec_q) stat_q <= {sh_q[6:0], sdo_l};
            cnt_q <= (rdst_q && sec_q) ? 17'(spcc_pkg::STAT_GAP_CYC)
                                       : 17'(spcc_pkg::CMD_GAP_CYC);
            st_q <= H_GAP;
          end
        end
        H_GAP: begin
          if (cnt_q != 17'h0) begin
            cnt_q <= cnt_q - 17'h1;
          end else if (more) begin
            sec_q <= 1'b1;
            sh_q <= b1_q;
            {ph_q, div_q} <= 8'h00;
            st_q <= H_FRAME;
          end else if (stop_q) begin
            cnt_q <= 17'(STOP_WAIT);
            st_q <= H_STOPW;
          end else begin
            st_q <= H_IDLE;
          end
        end
        H_STOPW: begin
          if (!cbn_l) cnt_q <= 17'(STOP_WAIT);
          else if (cnt_q == 17'h0) st_q <= H_IDLE;
          else cnt_q <= cnt_q - 17'h1;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // pins: clock high on odd half phases, frame select low through a byte
  assign link.sclk = (st_q == H_FRAME) && ph_q[0];
  assign link.cs_n = (st_q != H_FRAME);
  assign link.sdi = (st_q == H_FRAME) && sh_q[7];
endmodule : spcc_host
`default_nettype wire

// ==== src/spcc_link_if.sv ====
`default_nettype none
interface spcc_link_if;
  logic sclk; // serial clock, made by host
  logic cs_n; // frame select, low per byte
  logic sdi; // host to device data
  logic sdo; // device to host data
  logic cmd_busy_n; // device command busy pin
  modport dev (input sclk, input cs_n, input sdi, output sdo, output cmd_busy_n);
  modport host (output sclk, output cs_n, output sdi, input sdo, input cmd_busy_n);
endinterface : spcc_link_if
`default_nettype wire

// ==== src/spcc_pkg.sv ====
`default_nettype none
package spcc_pkg;
  // opcodes and opcode masks
  localparam logic [7:0] OP_READ_STATUS_CMD = 8'hb0;
  localparam logic [7:0] OP_ASET = 8'h04;
  localparam logic [7:0] OP_STOP = 8'h60;
  localparam logic [7:0] OP_LAUNCH = 8'h50;
  localparam logic [7:0] OP_POWER_DOWN_CMD = 8'h20;
  localparam logic [3:0] OP_PLAY_HI = 4'h4;
  localparam logic [3:0] OP_SET_HI = 4'h3;
  // status byte bit positions
  localparam int unsigned ST_BUSY_BIT = 5;
  localparam int unsigned ST_RDY_BIT = 0;
  // analog setting fields and reset value
  localparam int unsigned AS_FADE = 7;
  localparam int unsigned AS_DAG = 5;
  localparam int unsigned AS_AIG = 3;
  localparam int unsigned AS_DAC_POWER_EN = 2;
  localparam int unsigned AS_SPK_POWER_EN = 1;
  localparam int unsigned AS_POP = 0;
  localparam logic [7:0] AS_INIT = 8'h40;
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_M6 = 2'h1;
  // timing, clock 100 ns
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned FADE_US = 3000;
  localparam int unsigned TRANS_US = 100;
  localparam int unsigned RUP_S_US = 100;
  localparam int unsigned RUP_L_US = 300;
  localparam int unsigned RDN_S_US = 100;
  localparam int unsigned RDN_L_US = 300;
  localparam int unsigned CMD_GAP_US = 20;
  localparam int unsigned STAT_GAP_US = 20;
  localparam int unsigned STOP_WAIT_US = 12000;
  localparam int unsigned FADE_CYC = (FADE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TRANS_CYC = (TRANS_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RUP_S_CYC = (RUP_S_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RUP_L_CYC = (RUP_L_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RDN_S_CYC = (RDN_S_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RDN_L_CYC = (RDN_L_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CMD_GAP_CYC = (CMD_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STAT_GAP_CYC = (STAT_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STOP_WAIT_CYC = (STOP_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HALF_CYC = 8;
  // host register map
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_STAT = 8'h04;
  localparam int unsigned HC_TWO = 16;
  localparam int unsigned HC_RD = 17;
endpackage : spcc_pkg
`default_nettype wire

// ==== src/spcc_sync3.sv ====
`default_nettype none
// three-stage synchroniser; a level counts once stages two and three agree
module spcc_sync3 #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // raw pin and filtered result
  input wire logic din,
  output logic lvl,
  output logic rise,
  output logic fall
);
  logic s1_q, s2_q, s3_q, lvl_q; // stage one feeds only stage two
  wire agree = (s2_q == s3_q);
  // shift chain and filtered level
  always_ff @(posedge clock) begin
    if (!nrst) begin
      {s1_q, s2_q, s3_q, lvl_q} <= {4{INIT}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) lvl_q <= s3_q;
    end
  end
  assign lvl = lvl_q;
  assign rise = agree && s3_q && !lvl_q;
  assign fall = agree && !s3_q && lvl_q;
endmodule : spcc_sync3
`default_nettype wire
